// ==== mac_map.svh ====
// register offsets, field positions, reset values and widths of the multiply-accumulate datapath
// =====================================================================
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH

// =====================================================================
// register byte offsets
`define MAC_OFF_STATUS   6'h00
`define MAC_OFF_MASK     6'h04
`define MAC_OFF_ACC0     6'h10
`define MAC_OFF_ACC1     6'h14
`define MAC_OFF_ACC2     6'h18
`define MAC_OFF_ACC3     6'h1c
`define MAC_OFF_EXT_LO   6'h20
`define MAC_OFF_EXT_HI   6'h24

// =====================================================================
// status fields, reset values, accumulator sizes and response codes
`define MAC_ST_PAV_LSB   8
`define MAC_ST_MODE_LSB  4
`define MAC_ST_FLAG_LSB  0
`define MAC_MODE_RST     4'h0
`define MAC_MASK_RST     16'hffff
`define MAC_ACC_N        4
`define MAC_ACC_W        48
`define MAC_PROD_W       40
`define MAC_RESP_OKAY    2'b00
`define MAC_RESP_SLVERR  2'b10

`endif

// ==== mac_pkg.sv ====
// types shared by the multiply-accumulate datapath and its users
package mac_pkg;

  // =====================================================================
  // instruction kinds and shift selection
  typedef enum logic [1:0] {
    MAC_OP_ADD  = 2'b00,
    MAC_OP_SUB  = 2'b01,
    MAC_OP_UNSIGNED_MULTIPLY_INSTR = 2'b10,
    MAC_OP_SIGNED_MULTIPLY_INSTR = 2'b11
  } mac_op_t;

  typedef enum logic [1:0] {
    MAC_SH_NONE  = 2'b00,
    MAC_SH_LEFT  = 2'b01,
    MAC_SH_RIGHT = 2'b11
  } mac_shift_t;

  // =====================================================================
  // issue word from the operand execution pipeline
  typedef struct packed {
    mac_op_t     op;
    logic [1:0]  acc;
    logic        long_sz;
    logic        a_upper;
    logic        b_upper;
    mac_shift_t  shift;
    logic        with_load;
    logic [31:0] opa;
    logic [31:0] opb;
  } mac_issue_t;

  // operating mode: saturate, unsigned, fraction, round
  typedef struct packed {
    logic sat;
    logic uns;
    logic frac;
    logic rnd;
  } mac_mode_t;

endpackage

// ==== mac_datapath.sv ====
// multiply-accumulate datapath with AXI4-Lite register access
`timescale 1ns/1ps
`include "mac_map.svh"
module mac_datapath (
  input  wire logic                CLK_SYS,
  input  wire logic                RSTN,
  input  wire logic                ISSUE_VALID,
  input  wire mac_pkg::mac_issue_t ISSUE,
  output logic                     ISSUE_READY,
  output logic                     MUL_VALID,
  output logic [31:0]              MUL_RESULT,
  input  wire logic                AGEN_REQ,
  input  wire logic                AGEN_USE_MASK,
  input  wire logic [31:0]         AGEN_BASE,
  input  wire logic [2:0]          AGEN_INC,
  output logic                     AGEN_VALID,
  output logic [31:0]              AGEN_ADDR,
  output logic [31:0]              AGEN_NEXT,
  input  wire logic [5:0]          S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [5:0]          S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY
);

  // =====================================================================
  // helpers
  // operand select and widen to a 33-bit signed multiplier input
  function automatic logic [32:0] op_ext(input logic [31:0] r, input logic lng, input logic up,
                                         input logic sgn, input logic frc);
    logic [15:0] h;
    h = up ? r[31:16] : r[15:0];
    if (lng) op_ext = {sgn & r[31], r};
    else if (frc) op_ext = {h[15], h, 16'h0000};
    else op_ext = {{17{sgn & h[15]}}, h};
  endfunction

  function automatic logic [31:0] acc_word(input logic [47:0] a, input logic frc);
    acc_word = frc ? a[39:8] : a[31:0];
  endfunction

  function automatic logic [15:0] acc_ext(input logic [47:0] a, input logic frc);
    acc_ext = frc ? {a[47:40], a[7:0]} : a[47:32];
  endfunction

  function automatic logic [47:0] acc_join(input logic [15:0] e, input logic [31:0] w, input logic frc);
    acc_join = frc ? {e[15:8], w, e[7:0]} : {e, w};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // =====================================================================
  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // =====================================================================
  // architectural state
  logic [`MAC_ACC_W-1:0] acc_q [`MAC_ACC_N];
  logic [3:0]            pav_q;
  mac_pkg::mac_mode_t    mode_q;
  logic [3:0]            flag_q;
  logic [15:0]           mask_q;
  logic [31:0]           status_rd;

  assign status_rd = {20'h00000, pav_q, mode_q, flag_q};

  // =====================================================================
  // pipeline stage registers
  logic                  s1_v_q, s2_v_q, s3_v_q;
  mac_pkg::mac_op_t      s1_op_q, s2_op_q, s3_op_q;
  logic [1:0]            s1_acc_q, s2_acc_q, s3_acc_q;
  mac_pkg::mac_shift_t   s1_sh_q, s2_sh_q;
  logic                  s1_uns_q, s2_uns_q, s3_uns_q;
  logic                  s1_frc_q, s2_frc_q;
  logic                  s1_rnd_q, s2_rnd_q;
  logic [32:0]           s1_a_q, s1_b_q;
  logic [63:0]           s2_prod_q;
  logic [`MAC_ACC_W-1:0] s3_p48_q;
  logic                  s3_povf_q;
  logic [31:0]           s3_mul_q;
  logic                  issue_fire;
  logic                  pipe_empty;
  logic                  is_mac_in;
  logic                  frc_in, uns_in;
  logic signed [65:0]    prod_full;

  assign issue_fire = ISSUE_VALID && ISSUE_READY;
  assign pipe_empty = !issue_fire && !s1_v_q && !s2_v_q && !s3_v_q;
  assign is_mac_in  = !ISSUE.op[1];
  // integer multiplies ignore the fraction and sign mode
  assign frc_in     = is_mac_in && mode_q.frac;
  assign uns_in     = is_mac_in ? (mode_q.uns && !mode_q.frac) : (ISSUE.op == mac_pkg::MAC_OP_UNSIGNED_MULTIPLY_INSTR);

  // stage 1: operand latch, taken every cycle the core offers one while ISSUE_READY is high
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      s1_v_q   <= 1'b0;
      s1_op_q  <= mac_pkg::MAC_OP_ADD;
      s1_acc_q <= 2'b00;
      s1_sh_q  <= mac_pkg::MAC_SH_NONE;
      s1_uns_q <= 1'b0;
      s1_frc_q <= 1'b0;
      s1_rnd_q <= 1'b0;
      s1_a_q   <= 33'h0;
      s1_b_q   <= 33'h0;
    end else begin
      s1_v_q <= issue_fire;
      if (issue_fire) begin
        s1_op_q  <= ISSUE.op;
        s1_acc_q <= ISSUE.acc;
        s1_sh_q  <= is_mac_in ? ISSUE.shift : mac_pkg::MAC_SH_NONE;
        s1_uns_q <= uns_in;
        s1_frc_q <= frc_in;
        s1_rnd_q <= mode_q.rnd;
        s1_a_q   <= op_ext(ISSUE.opa, ISSUE.long_sz, ISSUE.a_upper, !uns_in, frc_in);
        s1_b_q   <= op_ext(ISSUE.opb, ISSUE.long_sz, ISSUE.b_upper, !uns_in, frc_in);
      end
    end
  end

  // stage 2: full 33x33 signed product, fully pipelined
  assign prod_full = $signed(s1_a_q) * $signed(s1_b_q);

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      s2_v_q    <= 1'b0;
      s2_op_q   <= mac_pkg::MAC_OP_ADD;
      s2_acc_q  <= 2'b00;
      s2_sh_q   <= mac_pkg::MAC_SH_NONE;
      s2_uns_q  <= 1'b0;
      s2_frc_q  <= 1'b0;
      s2_rnd_q  <= 1'b0;
      s2_prod_q <= 64'h0;
    end else begin
      s2_v_q    <= s1_v_q;
      s2_op_q   <= s1_op_q;
      s2_acc_q  <= s1_acc_q;
      s2_sh_q   <= s1_sh_q;
      s2_uns_q  <= s1_uns_q;
      s2_frc_q  <= s1_frc_q;
      s2_rnd_q  <= s1_rnd_q;
      s2_prod_q <= prod_full[63:0];
    end
  end

  // stage 3: reduce to 40 bits, round, shift, widen to 48
  logic        rnd_bit;
  logic [40:0] p41;
  logic [39:0] p40, p40s;
  logic        povf;

  always_comb begin
    rnd_bit = 1'b0;
    p41     = 41'h0;
    if (s2_frc_q) begin
      // round to nearest, ties to the even upper result
      rnd_bit = s2_rnd_q && s2_prod_q[23] && ((|s2_prod_q[22:0]) || s2_prod_q[24]);
      p41     = {s2_prod_q[63], s2_prod_q[63:24]} + {40'h0, rnd_bit};
      p40     = p41[39:0];
      povf    = p41[40] != p41[39];
    end else begin
      p40  = s2_prod_q[39:0];
      povf = s2_uns_q ? (s2_prod_q[63:40] != 24'h0) : (s2_prod_q[63:39] != {25{s2_prod_q[39]}});
    end
    unique case (s2_sh_q)
      mac_pkg::MAC_SH_LEFT: begin
        p40s = {p40[38:0], 1'b0};
        povf = povf || (s2_uns_q ? p40[39] : (p40[39] != p40[38]));
      end
      mac_pkg::MAC_SH_RIGHT: p40s = {p40[39] & !s2_uns_q, p40[39:1]};
      default: p40s = p40;                          // also covers the unused code 2'b10
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      s3_v_q    <= 1'b0;
      s3_op_q   <= mac_pkg::MAC_OP_ADD;
      s3_acc_q  <= 2'b00;
      s3_uns_q  <= 1'b0;
      s3_p48_q  <= '0;
      s3_povf_q <= 1'b0;
      s3_mul_q  <= 32'h0;
    end else begin
      s3_v_q    <= s2_v_q;
      s3_op_q   <= s2_op_q;
      s3_acc_q  <= s2_acc_q;
      s3_uns_q  <= s2_uns_q;
      s3_p48_q  <= {{8{p40s[39] & !s2_uns_q}}, p40s};
      s3_povf_q <= povf;
      s3_mul_q  <= s2_prod_q[31:0];
    end
  end

  // stage 4: accumulate into the destination, saturate, form flags
  logic [47:0] cur, res;
  logic [48:0] sum49;
  logic        sub, aovf, ovf, neg, ev;
  logic        acc_we;

  assign acc_we = s3_v_q && !s3_op_q[1];
  assign sub    = (s3_op_q == mac_pkg::MAC_OP_SUB);

  always_comb begin
    cur   = acc_q[s3_acc_q];
    sum49 = sub ? ({1'b0, cur} - {1'b0, s3_p48_q}) : ({1'b0, cur} + {1'b0, s3_p48_q});
    if (s3_uns_q) aovf = sum49[48];
    else aovf = ((cur[47] == s3_p48_q[47]) ^ sub) && (sum49[47] != cur[47]);
    ovf = aovf || s3_povf_q;
    neg = aovf ? cur[47] : (s3_p48_q[47] ^ sub);
    res = sum49[47:0];
    if (mode_q.sat && ovf) begin
      if (s3_uns_q) res = sub ? 48'h0 : 48'hffffffffffff;
      else res = neg ? 48'h800000000000 : 48'h7fffffffffff;
    end
    if (mode_q.frac) ev = res[47:39] != {9{res[39]}};
    else if (s3_uns_q) ev = res[47:32] != 16'h0;
    else ev = res[47:31] != {17{res[31]}};
  end

  // =====================================================================
  // AXI4-Lite slave; every access waits for the pipeline to drain
  logic [5:0]  aw_addr_q, ar_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        ar_pend_q;
  logic        wr_go, rd_go, wr_pend;
  logic [31:0] wr_val, rd_val;
  logic        wr_hit, rd_hit;

  assign wr_pend = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  assign wr_go   = wr_pend && pipe_empty;
  assign rd_go   = ar_pend_q && !S_AXI_RVALID && pipe_empty;

  // register read mux and write merge decode the same offsets, each from its own address
  always_comb begin
    rd_hit = 1'b1;
    unique case (ar_addr_q)
      `MAC_OFF_STATUS: rd_val = status_rd;
      `MAC_OFF_MASK:   rd_val = {16'h0000, mask_q};
      `MAC_OFF_ACC0:   rd_val = acc_word(acc_q[0], mode_q.frac);
      `MAC_OFF_ACC1:   rd_val = acc_word(acc_q[1], mode_q.frac);
      `MAC_OFF_ACC2:   rd_val = acc_word(acc_q[2], mode_q.frac);
      `MAC_OFF_ACC3:   rd_val = acc_word(acc_q[3], mode_q.frac);
      `MAC_OFF_EXT_LO: rd_val = {acc_ext(acc_q[1], mode_q.frac), acc_ext(acc_q[0], mode_q.frac)};
      `MAC_OFF_EXT_HI: rd_val = {acc_ext(acc_q[3], mode_q.frac), acc_ext(acc_q[2], mode_q.frac)};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
    wr_hit = 1'b1;
    unique case (aw_addr_q)
      `MAC_OFF_STATUS: wr_val = merge(status_rd, w_data_q, w_strb_q);
      `MAC_OFF_MASK:   wr_val = merge({16'h0000, mask_q}, w_data_q, w_strb_q);
      `MAC_OFF_ACC0, `MAC_OFF_ACC1, `MAC_OFF_ACC2, `MAC_OFF_ACC3:
        wr_val = merge(acc_word(acc_q[aw_addr_q[3:2]], mode_q.frac), w_data_q, w_strb_q);
      `MAC_OFF_EXT_LO, `MAC_OFF_EXT_HI:
        wr_val = merge({acc_ext(acc_q[{aw_addr_q[2], 1'b1}], mode_q.frac),
                        acc_ext(acc_q[{aw_addr_q[2], 1'b0}], mode_q.frac)}, w_data_q, w_strb_q);
      default: begin
        wr_val = 32'h0;
        wr_hit = 1'b0;
      end
    endcase
  end

  // write address and data are taken independently, then answered together
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `MAC_RESP_OKAY;
      aw_addr_q     <= 6'h00;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr_q     <= {S_AXI_AWADDR[5:2], 2'b00};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data_q     <= S_AXI_WDATA;
        w_strb_q     <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? `MAC_RESP_OKAY : `MAC_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // read path: address held until the pipeline is empty
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= `MAC_RESP_OKAY;
      ar_addr_q     <= 6'h00;
      ar_pend_q     <= 1'b0;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        ar_addr_q     <= {S_AXI_ARADDR[5:2], 2'b00};
        S_AXI_ARREADY <= 1'b0;
        ar_pend_q     <= 1'b1;
      end
      if (rd_go) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_val;
        S_AXI_RRESP  <= rd_hit ? `MAC_RESP_OKAY : `MAC_RESP_SLVERR;
        ar_pend_q    <= 1'b0;
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // issue is held off while a register access waits, so the drain ends
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) ISSUE_READY <= 1'b0;
    else ISSUE_READY <= !(ar_pend_q || wr_pend);
  end

  // =====================================================================
  // accumulator array: pipeline write-back or direct register load
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `MAC_ACC_N; i++) acc_q[i] <= '0;
    end else if (acc_we) begin
      acc_q[s3_acc_q] <= res;
    end else if (wr_go && wr_hit) begin
      unique case (aw_addr_q)
        `MAC_OFF_ACC0, `MAC_OFF_ACC1, `MAC_OFF_ACC2, `MAC_OFF_ACC3:
          // a direct load fills the extension as the mode's sign rule asks
          acc_q[aw_addr_q[3:2]] <= acc_join(mode_q.frac ? {{8{wr_val[31]}}, 8'h00} :
                                            {16{wr_val[31] & !mode_q.uns}}, wr_val, mode_q.frac);
        `MAC_OFF_EXT_LO, `MAC_OFF_EXT_HI: begin
          acc_q[{aw_addr_q[2], 1'b0}] <= acc_join(wr_val[15:0],
                                           acc_word(acc_q[{aw_addr_q[2], 1'b0}], mode_q.frac), mode_q.frac);
          acc_q[{aw_addr_q[2], 1'b1}] <= acc_join(wr_val[31:16],
                                           acc_word(acc_q[{aw_addr_q[2], 1'b1}], mode_q.frac), mode_q.frac);
        end
        default: ;
      endcase
    end
  end

  // sticky per-accumulator overflow; a new overflow beats a clear written through STATUS, an accumulator load clear wins
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pav_q <= 4'h0;
    end else begin
      if (wr_go && wr_hit && aw_addr_q == `MAC_OFF_STATUS)
        pav_q <= wr_val[`MAC_ST_PAV_LSB +: 4] | ((acc_we && ovf) ? (4'h1 << s3_acc_q) : 4'h0);
      else if (wr_go && wr_hit && aw_addr_q[5:4] == 2'b01)
        pav_q[aw_addr_q[3:2]] <= 1'b0;
      else if (acc_we && ovf)
        pav_q[s3_acc_q] <= 1'b1;
    end
  end

  // mode field and indicator flags
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `MAC_MODE_RST;
      flag_q <= 4'h0;
    end else begin
      if (wr_go && wr_hit && aw_addr_q == `MAC_OFF_STATUS) begin
        mode_q <= wr_val[`MAC_ST_MODE_LSB +: 4];
        flag_q <= wr_val[`MAC_ST_FLAG_LSB +: 4];
      end
      if (acc_we)
        flag_q <= {res[47], res == 48'h0, pav_q[s3_acc_q] | ovf, ev};
    end
  end

  // mask register
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) mask_q <= `MAC_MASK_RST;
    else if (wr_go && wr_hit && aw_addr_q == `MAC_OFF_MASK) mask_q <= wr_val[15:0];
  end

  // =====================================================================
  // integer multiply result, four edges after issue whatever the data
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      MUL_VALID  <= 1'b0;
      MUL_RESULT <= 32'h0;
    end else begin
      MUL_VALID <= s3_v_q && s3_op_q[1];
      if (s3_v_q && s3_op_q[1]) MUL_RESULT <= s3_mul_q;
    end
  end

  // operand address for multiply-with-load; mask makes the buffer circular
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      AGEN_VALID <= 1'b0;
      AGEN_ADDR  <= 32'h0;
      AGEN_NEXT  <= 32'h0;
    end else begin
      AGEN_VALID <= AGEN_REQ;
      if (AGEN_REQ) begin
        AGEN_ADDR <= AGEN_USE_MASK ? (AGEN_BASE & {16'hffff, mask_q}) : AGEN_BASE;
        AGEN_NEXT <= AGEN_USE_MASK ? ((AGEN_BASE + {29'h0, AGEN_INC}) & {16'hffff, mask_q})
                                   : (AGEN_BASE + {29'h0, AGEN_INC});
      end
    end
  end

endmodule // mac_datapath

// ==== mac_oep_model.sv ====
// operand execution pipeline model: queues issue words and offers them in order
`timescale 1ns/1ps
module mac_oep_model (
  input  wire logic           CLK_SYS,
  input  wire logic           ISSUE_READY,
  output logic                ISSUE_VALID,
  output mac_pkg::mac_issue_t ISSUE
);
  mac_pkg::mac_issue_t q[$];
  initial begin
    ISSUE_VALID = 1'b0;
    ISSUE = '0;
  end
  // ==========
  // head word held until taken; bus inverted on every idle cycle, so the last word shows again only every other cycle
  always @(posedge CLK_SYS) begin
    if (ISSUE_VALID && ISSUE_READY) void'(q.pop_front());
    ISSUE_VALID <= q.size() != 0;
    ISSUE <= (q.size() != 0) ? q[0] : ~ISSUE;
  end
endmodule // mac_oep_model

// ==== mac_checker.sv ====
// port-level assertions for the multiply-accumulate datapath
`timescale 1ns/1ps
module mac_checker (
  input wire logic                CLK_SYS,
  input wire logic                RSTN,
  input wire logic                ISSUE_VALID,
  input wire mac_pkg::mac_issue_t ISSUE,
  input wire logic                ISSUE_READY,
  input wire logic                MUL_VALID,
  input wire logic [31:0]         MUL_RESULT,
  input wire logic                AGEN_REQ,
  input wire logic                AGEN_USE_MASK,
  input wire logic [31:0]         AGEN_BASE,
  input wire logic [2:0]          AGEN_INC,
  input wire logic                AGEN_VALID,
  input wire logic [31:0]         AGEN_ADDR,
  input wire logic [31:0]         AGEN_NEXT,
  input wire logic                S_AXI_ARVALID,
  input wire logic                S_AXI_ARREADY,
  input wire logic                S_AXI_RVALID,
  input wire logic                S_AXI_RREADY,
  input wire logic [31:0]         S_AXI_RDATA
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // ==========
  // issue take; op bit 1 marks the plain multiplies
  wire tk  = ISSUE_VALID && ISSUE_READY;
  wire mul = tk && ISSUE.op[1];
  a_mul_latency: assert property (mul |-> ##4 MUL_VALID)
    else $error("multiply result pulse missing at fixed latency");
  a_mul_origin: assert property (MUL_VALID |-> $past(mul, 4))
    else $error("multiply result pulse without matching issue");
  a_mul_value: assert property (mul && ISSUE.long_sz |-> ##4 MUL_RESULT == $past(ISSUE.opa, 4) * $past(ISSUE.opb, 4))
    else $error("multiply result low word wrong");
  a_agen_pulse: assert property (AGEN_REQ |=> AGEN_VALID)
    else $error("address answer missing");
  a_agen_origin: assert property (AGEN_VALID |-> $past(AGEN_REQ))
    else $error("address answer without request");
  a_agen_plain: assert property (AGEN_REQ && !AGEN_USE_MASK |=>
    AGEN_ADDR == $past(AGEN_BASE) && AGEN_NEXT == $past(AGEN_BASE) + $past(AGEN_INC))
    else $error("unmasked address or increment wrong");
  // issue ready is registered from the pending flag, so it falls one edge after the take
  a_read_stall: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> ##1 !ISSUE_READY)
    else $error("issue accepted while register read pending");
  a_read_drain: assert property ($rose(S_AXI_RVALID) |-> !$past(tk) && !$past(tk, 2))
    else $error("read answered before pipeline drained");
  a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before accepted");
  c_mul: cover property (mul);
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
  c_mask: cover property (AGEN_REQ && AGEN_USE_MASK);
endmodule // mac_checker

// ==== tb_multiply_accumulate_datapath.sv ====
// self-checking bench for the multiply-accumulate datapath
`timescale 1ns/1ps
`include "mac_map.svh"
module tb_multiply_accumulate_datapath;
  logic CLK_SYS = 1'b0, RSTN = 1'b0, AGEN_REQ = 1'b0, AGEN_USE_MASK = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
  logic [31:0] AGEN_BASE = 32'h0, S_AXI_WDATA = 32'h0;
  logic [2:0]  AGEN_INC = 3'h0;
  logic [5:0]  S_AXI_AWADDR = 6'h0, S_AXI_ARADDR = 6'h0;
  logic [3:0]  S_AXI_WSTRB = 4'hf;
  logic ISSUE_VALID, ISSUE_READY, MUL_VALID, AGEN_VALID, S_AXI_AWREADY, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [31:0] MUL_RESULT, AGEN_ADDR, AGEN_NEXT, S_AXI_RDATA, d;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  mac_pkg::mac_issue_t ISSUE;
  int n_errors = 0, num_checks = 0;
  always #25 CLK_SYS = ~CLK_SYS;
  mac_datapath u_dut (.*);
  mac_oep_model u_oep (.*);
  // ==========
  // shared bus, issue and compare tasks
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic ao, wo;
    ao = 1'b0;
    wo = 1'b0;
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(ao && wo)) begin
      @(negedge CLK_SYS);
      ao = ao | (S_AXI_AWREADY === 1'b1);
      wo = wo | (S_AXI_WREADY === 1'b1);
      @(posedge CLK_SYS);
      if (ao) S_AXI_AWVALID <= 1'b0;
      if (wo) S_AXI_WVALID <= 1'b0;
    end
    do @(negedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
    @(posedge CLK_SYS);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] m, e);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(negedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
    @(posedge CLK_SYS);
    S_AXI_ARVALID <= 1'b0;
    do @(negedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    @(posedge CLK_SYS);
    S_AXI_RREADY <= 1'b0;
    chk(d & m, e);
  endtask
  // pushed one per cycle, so the model issues back to back
  task automatic p(input mac_pkg::mac_op_t o, input logic [1:0] n, input mac_pkg::mac_shift_t s,
                   input logic [31:0] a, b, input logic [2:0] h = 3'b100);
    @(negedge CLK_SYS);
    u_oep.q.push_back(mac_pkg::mac_issue_t'{o, n, h[2], h[1], h[0], s, 1'b1, a, b});
  endtask
  task automatic idle;
    do @(negedge CLK_SYS); while (ISSUE_VALID !== 1'b0);
  endtask
  task automatic mw(input logic [31:0] e);
    do @(negedge CLK_SYS); while (MUL_VALID !== 1'b1);
    chk(MUL_RESULT, e);
  endtask
  task automatic agen(input logic m, input logic [31:0] ea, en);
    @(posedge CLK_SYS);
    AGEN_REQ <= 1'b1;
    AGEN_USE_MASK <= m;
    AGEN_BASE <= 32'h1234_5678;
    AGEN_INC <= 3'h4;
    @(posedge CLK_SYS);
    AGEN_REQ <= 1'b0;
    @(negedge CLK_SYS);
    chk(AGEN_ADDR, ea);
    chk(AGEN_NEXT, en);
  endtask
  // ==========
  // scenarios
  task automatic t_regs;
    rc(`MAC_OFF_MASK, 32'hffffffff, 32'h0000ffff);
    rc(`MAC_OFF_STATUS, 32'hffffffff, 32'h0);
    wr(6'h3c, 32'h1);
    chk({30'h0, r}, 32'h2);
    rc(6'h3c, 32'hffffffff, 32'h0);
    chk({30'h0, r}, 32'h2);
  endtask
  task automatic t_mac;
    wr(`MAC_OFF_ACC0, 32'h5);
    p(mac_pkg::MAC_OP_ADD, 2'd0, mac_pkg::MAC_SH_NONE, 32'h3, 32'h4);
    p(mac_pkg::MAC_OP_ADD, 2'd2, mac_pkg::MAC_SH_LEFT, 32'h3, 32'h5);
    p(mac_pkg::MAC_OP_ADD, 2'd2, mac_pkg::MAC_SH_RIGHT, 32'h3, 32'h4);
    p(mac_pkg::MAC_OP_ADD, 2'd3, mac_pkg::MAC_SH_NONE, 32'h0007_0002, 32'h0009_0003, 3'b010);
    p(mac_pkg::MAC_OP_SUB, 2'd1, mac_pkg::MAC_SH_NONE, 32'h2, 32'h3);
    idle;
    rc(`MAC_OFF_ACC0, 32'hffffffff, 32'h11);
    rc(`MAC_OFF_ACC2, 32'hffffffff, 32'h24);
    rc(`MAC_OFF_ACC3, 32'hffffffff, 32'h15);
    rc(`MAC_OFF_ACC1, 32'hffffffff, 32'hffff_fffa);
    rc(`MAC_OFF_EXT_LO, 32'hffffffff, 32'hffff_0000);
    rc(`MAC_OFF_STATUS, 32'h8, 32'h8);
  endtask
  task automatic t_sticky;
    p(mac_pkg::MAC_OP_ADD, 2'd1, mac_pkg::MAC_SH_NONE, 32'h7fffffff, 32'h7fffffff);
    idle;
    rc(`MAC_OFF_STATUS, 32'h202, 32'h202);
    wr(`MAC_OFF_ACC1, 32'h0);
    rc(`MAC_OFF_STATUS, 32'h200, 32'h0);
  endtask
  task automatic t_mul;
    p(mac_pkg::MAC_OP_UNSIGNED_MULTIPLY_INSTR, 2'd0, mac_pkg::MAC_SH_NONE, 32'h0001_0000, 32'h0003_0005);
    p(mac_pkg::MAC_OP_SIGNED_MULTIPLY_INSTR, 2'd0, mac_pkg::MAC_SH_NONE, 32'hffff_fffe, 32'h3);
    mw(32'h0005_0000);
    mw(32'hffff_fffa);
  endtask
  task automatic t_mode;
    wr(`MAC_OFF_MASK, 32'h00ff);
    agen(1'b1, 32'h1234_0078, 32'h1234_007c);
    agen(1'b0, 32'h1234_5678, 32'h1234_567c);
    wr(`MAC_OFF_STATUS, 32'h40);
    wr(`MAC_OFF_ACC0, 32'h0);
    p(mac_pkg::MAC_OP_ADD, 2'd0, mac_pkg::MAC_SH_NONE, 32'hffff_ffff, 32'h2);
    idle;
    rc(`MAC_OFF_EXT_LO, 32'hffff, 32'h1);
    rc(`MAC_OFF_STATUS, 32'hf0, 32'h40);
    // unsigned saturating subtract clamps at zero and marks the sticky bit
    wr(`MAC_OFF_STATUS, 32'hc0);
    wr(`MAC_OFF_ACC3, 32'h0);
    p(mac_pkg::MAC_OP_SUB, 2'd3, mac_pkg::MAC_SH_NONE, 32'h1, 32'h1);
    idle;
    rc(`MAC_OFF_ACC3, 32'hffffffff, 32'h0);
    rc(`MAC_OFF_STATUS, 32'hfff, 32'h8c6);
    // rounded fractions: halfword product lands in the word, odd tie rounds up
    wr(`MAC_OFF_STATUS, 32'h30);
    wr(`MAC_OFF_ACC1, 32'h0);
    p(mac_pkg::MAC_OP_ADD, 2'd1, mac_pkg::MAC_SH_NONE, 32'h4000_0000, 32'h0000_4000, 3'b010);
    p(mac_pkg::MAC_OP_ADD, 2'd1, mac_pkg::MAC_SH_NONE, 32'h1, 32'h0180_0000);
    idle;
    rc(`MAC_OFF_ACC1, 32'hffffffff, 32'h1000_0000);
    rc(`MAC_OFF_EXT_LO, 32'h00ff_0000, 32'h0002_0000);
  endtask
  task automatic complete_run;
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    t_regs;
    t_mac;
    t_sticky;
    t_mul;
    t_mode;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    n_errors++;
    complete_run;
  end
endmodule // tb_multiply_accumulate_datapath
bind mac_datapath mac_checker u_chk (.*);
